/* File: rtl/bipf_top.sv */
// module: binary input channel, static level or pulse-frequency measurement
//
// The register addresses and the APB slave port were chosen for this implementation.
module bipf_top #(
    parameter int GATE_CYCLES = bipf_pkg::GATE_CYCLES,
    parameter int HIST_DEPTH = 64
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bipf_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // binary input pin
    input wire logic bin_in,
    // channel results
    output logic input_active,
    output logic signed [31:0] proc_value,
    output logic value_update
);
    import bipf_pkg::*;

    localparam int PTR_W = $clog2(HIST_DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // maps an address onto a register offset, or the unmapped marker
    function automatic logic [ADDR_W-1:0] dec_addr(input logic [ADDR_W-1:0] a);
        dec_addr = (a[1:0] == 2'h0 && a <= OFS_VALUE) ? a : ADDR_NONE;
    endfunction

    // keeps a written setting inside its legal range
    function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                 input logic signed [31:0] lo,
                                                 input logic signed [31:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic en_ff;
    logic mode_ff;
    logic lvl_ff;
    logic [1:0] var_ff;
    logic [16:0] fmax_ff;
    logic signed [31:0] lrv_ff;
    logic signed [31:0] urv_ff;
    logic [5:0] damp_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_data;
    logic setup;
    logic wr_acc;
    logic damp_wr;
    logic pulse_on;
    logic pin_q_ff;
    logic [31:0] gate_cnt_ff;
    logic gate_end;
    logic [15:0] edge_cnt_ff;
    logic [22:0] hz100;
    logic over;
    logic [16:0] freq_now;
    logic [16:0] freq_ff;
    logic over_ff;
    logic use_scale;
    bipf_state_t st_ff;
    logic div_start_ff;
    logic signed [DIV_W-1:0] dividend_ff;
    logic [DIV_W-1:0] divisor_ff;
    logic signed [31:0] raw_ff;
    logic active_ff;
    logic signed [31:0] value_ff;
    logic update_ff;
    logic signed [31:0] span;
    logic signed [31:0] hist_ff [HIST_DEPTH];
    logic [PTR_W-1:0] wp_ff;
    logic [6:0] fill_ff;
    logic signed [SUM_W-1:0] sum_ff;
    logic [6:0] navg;
    logic drop;
    logic signed [31:0] oldest;
    logic signed [SUM_W-1:0] nxt_sum;
    logic [6:0] nxt_fill;
    logic push;

    bipf_div_if dv ();

    bipf_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .dv(dv.div)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb slave

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pready_ff && pwrite;
    assign damp_wr = wr_acc && (dec_addr(paddr) == OFS_DAMP);

    // settings; out-of-range values are clipped rather than refused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= EN_RST;
            mode_ff <= MODE_RST;
            lvl_ff <= LVL_RST;
            var_ff <= VAR_RST;
            fmax_ff <= FMAX_RST;
            lrv_ff <= LRV_RST;
            urv_ff <= URV_RST;
            damp_ff <= DAMP_RST;
        end else if (wr_acc) begin
            unique case (dec_addr(paddr))
                OFS_CTRL: begin
                    en_ff <= pwdata[CTRL_EN_BIT];
                    mode_ff <= pwdata[CTRL_MODE_BIT];
                    lvl_ff <= pwdata[CTRL_LVL_BIT];
                    var_ff <= pwdata[CTRL_VAR_LSB+:2];
                end
                OFS_FMAX: fmax_ff <= 17'(clamp(pwdata, FMAX_MIN, FMAX_MAX));
                OFS_LRV: lrv_ff <= clamp(pwdata, LRV_MIN, LRV_MAX);
                OFS_URV: urv_ff <= clamp(pwdata, URV_MIN, URV_MAX);
                OFS_DAMP: damp_ff <= 6'(clamp(pwdata, DAMP_MIN, DAMP_MAX));
                default: ;
            endcase
        end
    end

    // read multiplexer; reserved bits read zero
    always_comb begin
        rd_data = 32'h00000000;
        unique case (dec_addr(paddr))
            OFS_CTRL: begin
                rd_data[CTRL_EN_BIT] = en_ff;
                rd_data[CTRL_MODE_BIT] = mode_ff;
                rd_data[CTRL_LVL_BIT] = lvl_ff;
                rd_data[CTRL_VAR_LSB+:2] = var_ff;
            end
            OFS_FMAX: rd_data = 32'(fmax_ff);
            OFS_LRV: rd_data = lrv_ff;
            OFS_URV: rd_data = urv_ff;
            OFS_DAMP: rd_data = 32'(damp_ff);
            OFS_STAT: begin
                rd_data[STAT_ACT_BIT] = active_ff;
                rd_data[STAT_OVR_BIT] = over_ff;
            end
            OFS_FREQ: rd_data = 32'(freq_ff);
            OFS_VALUE: rd_data = value_ff;
            default: ;
        endcase
    end

    // zero-wait answer: data and ready are registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && (dec_addr(paddr) == ADDR_NONE);
            if (setup && !pwrite) begin
                prdata_ff <= rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // static level input

    // active flag only in static mode with the channel switched on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_ff <= 1'b0;
        end else begin
            active_ff <= en_ff && !mode_ff && (bin_in == lvl_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse counting over a one-second gate

    assign pulse_on = en_ff && mode_ff;
    assign gate_end = (gate_cnt_ff == 32'(GATE_CYCLES - 1));

    // gate timer restarts whenever the measurement is switched off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_cnt_ff <= 32'h00000000;
        end else if (!pulse_on || gate_end) begin
            gate_cnt_ff <= 32'h00000000;
        end else begin
            gate_cnt_ff <= gate_cnt_ff + 32'h00000001;
        end
    end

    // rising edges; an edge in the gate's last cycle is dropped, one count at most
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q_ff <= 1'b0;
            edge_cnt_ff <= 16'h0000;
        end else begin
            pin_q_ff <= bin_in;
            if (!pulse_on || gate_end) begin
                edge_cnt_ff <= 16'h0000;
            end else if (bin_in && !pin_q_ff && edge_cnt_ff != 16'hFFFF) begin
                edge_cnt_ff <= edge_cnt_ff + 16'h0001;
            end
        end
    end

    // gate of one second gives whole hertz, kept in hundredths
    assign hz100 = 23'(edge_cnt_ff) * 23'(HZ_SCALE);
    assign over = hz100 > 23'(fmax_ff);
    assign freq_now = over ? fmax_ff : hz100[16:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_ff <= 17'h00000;
            over_ff <= 1'b0;
        end else if (!pulse_on) begin
            freq_ff <= 17'h00000;
            over_ff <= 1'b0;
        end else if (gate_end) begin
            freq_ff <= freq_now;
            over_ff <= over;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scaling and averaging sequencer

    assign use_scale = (var_ff == VAR_PARAM) || (var_ff == VAR_FLOW);
    assign span = urv_ff - lrv_ff;
    assign push = (st_ff == ST_PUSH);

    // one divider serves both scaling and averaging, traded for latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= ST_IDLE;
            div_start_ff <= 1'b0;
            dividend_ff <= '0;
            divisor_ff <= '0;
            raw_ff <= 32'h00000000;
            value_ff <= 32'h00000000;
            update_ff <= 1'b0;
        end else begin
            div_start_ff <= 1'b0;
            update_ff <= 1'b0;
            if (!pulse_on) begin
                st_ff <= ST_IDLE;
                value_ff <= 32'h00000000;
            end else begin
                unique case (st_ff)
                    ST_IDLE: begin
                        if (gate_end && use_scale) begin
                            // value = lrv + span * f / fmax, exact span at f = fmax
                            dividend_ff <= signed'(DIV_W'(span)) * signed'(DIV_W'(freq_now));
                            divisor_ff <= DIV_W'(fmax_ff);
                            div_start_ff <= 1'b1;
                            st_ff <= ST_SCALE;
                        end else if (gate_end) begin
                            raw_ff <= 32'(freq_now);
                            st_ff <= ST_PUSH;
                        end
                    end
                    ST_SCALE: begin
                        if (dv.done) begin
                            raw_ff <= lrv_ff + signed'(dv.quotient[31:0]);
                            st_ff <= ST_PUSH;
                        end
                    end
                    ST_PUSH: begin
                        if (nxt_fill > 7'h01) begin
                            dividend_ff <= DIV_W'(nxt_sum);
                            divisor_ff <= DIV_W'(nxt_fill);
                            div_start_ff <= 1'b1;
                            st_ff <= ST_AVG;
                        end else begin
                            value_ff <= raw_ff;
                            update_ff <= 1'b1;
                            st_ff <= ST_IDLE;
                        end
                    end
                    ST_AVG: begin
                        if (dv.done) begin
                            value_ff <= signed'(dv.quotient[31:0]);
                            update_ff <= 1'b1;
                            st_ff <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    assign dv.start = div_start_ff;
    assign dv.dividend = dividend_ff;
    assign dv.divisor = divisor_ff;

    ////////////////////////////////////////////////////////////////////////
    // moving-average window, one sample per gate second

    // damping of 0 or 1 s holds a single sample, so no smoothing
    assign navg = (damp_ff <= 6'h01) ? 7'h01 : 7'(damp_ff);
    assign drop = (fill_ff >= navg);
    assign oldest = hist_ff[wp_ff - PTR_W'(navg)];
    assign nxt_sum = sum_ff + SUM_W'(raw_ff) - (drop ? SUM_W'(oldest) : SUM_W'(0));
    assign nxt_fill = drop ? fill_ff : fill_ff + 7'h01;

    // sample storage needs no reset: the fill count guards every read
    always_ff @(posedge pclk) begin
        if (push) begin
            hist_ff[wp_ff] <= raw_ff;
        end
    end

    // a new damping time restarts the window instead of mixing lengths
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_ff <= '0;
            fill_ff <= 7'h00;
            sum_ff <= '0;
        end else if (damp_wr || !pulse_on) begin
            wp_ff <= '0;
            fill_ff <= 7'h00;
            sum_ff <= '0;
        end else if (push) begin
            wp_ff <= wp_ff + PTR_W'(1);
            fill_ff <= nxt_fill;
            sum_ff <= nxt_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign input_active = active_ff;
    assign proc_value = value_ff;
    assign value_update = update_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_gate_start;
        st_ff == ST_IDLE && gate_end && pulse_on;
    endsequence

    sequence seq_scale_zero;
        seq_gate_start and (use_scale && freq_now == 17'h00000);
    endsequence

    sequence seq_scale_full;
        seq_gate_start and (use_scale && freq_now == fmax_ff);
    endsequence

    chk_enable_off: assert property (!en_ff |=> !input_active && proc_value == 32'h00000000)
        else $error("disabled channel still drives a result");
    chk_mode_pulse: assert property (mode_ff |=> !input_active)
        else $error("active flag raised in pulse-frequency mode");
    chk_static_lvl: assert property (en_ff && !mode_ff && (bin_in == lvl_ff) |=> input_active)
        else $error("selected level did not raise active flag");
    chk_pulse_result: assert property (seq_gate_start |-> ##[2:150] (value_update || !pulse_on))
        else $error("no process value after gate closed");
    chk_fmax_range: assert property (fmax_ff >= 17'(FMAX_MIN) && fmax_ff <= 17'(FMAX_MAX))
        else $error("maximum frequency out of range");
    chk_freq_bound: assert property (gate_end && pulse_on && over |=> freq_ff == $past(fmax_ff))
        else $error("frequency above maximum registered");
    chk_var_freq: assert property (seq_gate_start and !use_scale |=> push && raw_ff == 32'($past(freq_now)))
        else $error("frequency variable not passed through");
    // push comes 51 cycles after the gate: one to start, 48 divide steps, one to add, one to push
    chk_zero_lrv: assert property (seq_scale_zero |-> ##51 (push && raw_ff == lrv_ff) or !pulse_on)
        else $error("zero frequency did not give lower range value");
    chk_full_urv: assert property (seq_scale_full |-> ##51 (push && raw_ff == urv_ff) or !pulse_on)
        else $error("maximum frequency did not give upper range value");
    chk_no_damp: assert property (push && damp_ff <= 6'h01 |=> value_update && proc_value == $past(raw_ff))
        else $error("undamped sample was averaged");
    chk_range_set: assert property (lrv_ff <= 32'sh0 && urv_ff >= 32'sh0 && damp_ff <= 6'(DAMP_MAX))
        else $error("range or damping setting out of bounds");
endmodule // bipf_top

/* File: shared/bipf_pkg.sv */
// package: constants, register map and types of the binary input channel
//
// Overview of operation
// - enable bit switches the input channel on or off; on after reset
// - mode bit selects static level or pulse-frequency input; static after reset
// - static mode flags active when pin equals selected level; high by default
// - pulse-frequency mode turns the measured pulse rate into a process value
// - maximum frequency settable 100.00 to 1000.00 Hz, default 1000.00 Hz
// - rates above the maximum frequency are not registered, clipped to maximum
// - result reported as frequency, parameter or flow rate; frequency by default
// - zero frequency maps to lower range value, -2000.00 to 0.00, default 0.00
// - maximum frequency maps to upper range value, 0.00 to 10000.00
// - moving average over damping time 0 to 60 s; zero means none
package bipf_pkg;
    // apb map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FMAX = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LRV = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_URV = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_DAMP = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_FREQ = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_VALUE = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_NONE = 8'hFF;
    // control field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int CTRL_LVL_BIT = 2;
    localparam int CTRL_VAR_LSB = 4;
    localparam int STAT_ACT_BIT = 0;
    localparam int STAT_OVR_BIT = 1;
    // reset values
    localparam logic EN_RST = 1'b1;
    localparam logic MODE_RST = 1'b0;
    localparam logic LVL_RST = 1'b1;
    localparam logic [1:0] VAR_RST = 2'h0;
    localparam logic [16:0] FMAX_RST = 17'h186A0;
    localparam logic signed [31:0] LRV_RST = 32'h00000000;
    localparam logic signed [31:0] URV_RST = 32'h00000000;
    localparam logic [5:0] DAMP_RST = 6'h00;
    // variable codes
    localparam logic [1:0] VAR_FREQ = 2'h0;
    localparam logic [1:0] VAR_PARAM = 2'h1;
    localparam logic [1:0] VAR_FLOW = 2'h2;
    // setting limits, values in hundredths, damping in whole seconds
    localparam logic signed [31:0] FMAX_MIN = 32'h00002710;
    localparam logic signed [31:0] FMAX_MAX = 32'h000186A0;
    localparam logic signed [31:0] LRV_MIN = 32'hFFFCF2C0;
    localparam logic signed [31:0] LRV_MAX = 32'h00000000;
    localparam logic signed [31:0] URV_MIN = 32'h00000000;
    localparam logic signed [31:0] URV_MAX = 32'h000F4240;
    localparam logic signed [31:0] DAMP_MIN = 32'h00000000;
    localparam logic signed [31:0] DAMP_MAX = 32'h0000003C;
    // timing
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int GATE_TIME_MS = 1000;
    localparam int GATE_CYCLES = CLK_FREQ_HZ / 1000 * GATE_TIME_MS;
    localparam int HZ_SCALE = 100;
    localparam int DIV_W = 48;
    localparam int SUM_W = 40;
    typedef enum logic [1:0] {ST_IDLE, ST_SCALE, ST_PUSH, ST_AVG} bipf_state_t;
endpackage

/* File: shared/bipf_div_if.sv */
// interface: request and answer between the channel and its divider
interface bipf_div_if;
    import bipf_pkg::*;
    logic start;
    logic signed [DIV_W-1:0] dividend;
    logic [DIV_W-1:0] divisor;
    logic done;
    logic signed [DIV_W-1:0] quotient;
    modport req (output start, dividend, divisor, input done, quotient);
    modport div (input start, dividend, divisor, output done, quotient);
endinterface

/* File: rtl/bipf_div.sv */
// module: sequential signed divider, one quotient bit per clock
module bipf_div (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // division request
    bipf_div_if.div dv
);
    import bipf_pkg::*;

    logic [DIV_W-1:0] rem_ff;
    logic [DIV_W-1:0] quo_ff;
    logic [DIV_W-1:0] den_ff;
    logic [6:0] cnt_ff;
    logic neg_ff;
    logic busy_ff;
    logic done_ff;
    logic [DIV_W:0] trial;

    // remainder stays below divisor, so the top bit is a clean borrow
    assign trial = {rem_ff, quo_ff[DIV_W-1]} - {1'b0, den_ff};

    // restoring division on magnitudes; sign put back at the end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_ff <= '0;
            quo_ff <= '0;
            den_ff <= '0;
            cnt_ff <= '0;
            neg_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (dv.start && !busy_ff) begin
            rem_ff <= '0;
            quo_ff <= dv.dividend[DIV_W-1] ? DIV_W'(-dv.dividend) : dv.dividend;
            den_ff <= dv.divisor;
            neg_ff <= dv.dividend[DIV_W-1];
            cnt_ff <= 7'(DIV_W);
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
        end else if (busy_ff) begin
            if (!trial[DIV_W]) begin
                rem_ff <= trial[DIV_W-1:0];
                quo_ff <= {quo_ff[DIV_W-2:0], 1'b1};
            end else begin
                rem_ff <= {rem_ff[DIV_W-2:0], quo_ff[DIV_W-1]};
                quo_ff <= {quo_ff[DIV_W-2:0], 1'b0};
            end
            cnt_ff <= cnt_ff - 7'h01;
            if (cnt_ff == 7'h01) begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
            end
        end else begin
            done_ff <= 1'b0;
        end
    end

    assign dv.done = done_ff;
    assign dv.quotient = neg_ff ? DIV_W'(-quo_ff) : quo_ff;
endmodule // bipf_div

/* File: verification/bipf_pulse_src.sv */
// partner model: binary source giving a static level or a pulse train
module bipf_pulse_src (
    // clock
    input wire logic pclk,
    // settings from the bench
    input wire logic [7:0] period,
    input wire logic level,
    // pin towards the channel
    output logic bin_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_ff = 8'h00;
    ////////////////////////////////////////////////////////////
    // one high cycle per period, so one rising edge per period from period 2 up; period 1 stays high, period 0 holds the level
    always_ff @(posedge pclk) begin
        cnt_ff <= (cnt_ff + 8'h01 >= period) ? 8'h00 : cnt_ff + 8'h01;
        bin_out <= (period == 8'h00) ? level : (cnt_ff == 8'h00);
    end
endmodule // bipf_pulse_src

/* File: verification/bipf_top_bench.sv */
// testbench: binary input channel driven over apb and by a pulse source
module bipf_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import bipf_pkg::*;
    typedef struct {logic [ADDR_W-1:0] a; logic wr; logic [31:0] d; logic [31:0] e; logic er;} bipf_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, level = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, bin_in, input_active, value_update;
    logic signed [31:0] proc_value;
    logic [7:0] period = 8'h00;
    logic [7:0] st[6] = '{8'h53, 8'h50, 8'h11, 8'h12, 8'h00, 8'h72};
    int num_errors = 0, n_tests = 0;
    // reset values first, then out-of-range writes that must be clipped
    bipf_row_t rows[10] = '{
        '{OFS_CTRL, 1'b0, 32'h0, 32'h05, 1'b0}, '{OFS_FMAX, 1'b0, 32'h0, 32'h186A0, 1'b0},
        '{OFS_LRV, 1'b0, 32'h0, 32'h0, 1'b0}, '{OFS_URV, 1'b0, 32'h0, 32'h0, 1'b0},
        '{OFS_DAMP, 1'b0, 32'h0, 32'h0, 1'b0}, '{OFS_FMAX, 1'b1, 32'h1F4, 32'h2710, 1'b0},
        '{OFS_LRV, 1'b1, 32'hFFFB6C20, 32'hFFFCF2C0, 1'b0}, '{OFS_URV, 1'b1, 32'h1E8480, 32'hF4240, 1'b0},
        '{OFS_DAMP, 1'b1, 32'h64, 32'h3C, 1'b0}, '{8'h20, 1'b0, 32'h0, 32'h0, 1'b1}};
    // short gate keeps the run small; one edge per gate is still 100 hundredths
    bipf_top #(.GATE_CYCLES(1000), .HIST_DEPTH(64)) bipf_top_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bin_in, .input_active, .proc_value, .value_update);
    bipf_pulse_src bipf_pulse_src_inst (.pclk, .period, .level, .bin_out(bin_in));
    ////////////////////////////////////////////////////////////
    // clock, 5 ns period
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic results();
        $display("errors %0d tests %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic hang();
        num_errors++;
        results();
    endtask
    // unsigned difference: got may trail exp by up to tol, an unknown never passes
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got, logic [31:0] tol = 32'h0);
        n_tests++;
        if (((exp - got) <= tol) !== 1'b1) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(logic wr, logic [ADDR_W-1:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i <= 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
            if (i == 20) hang();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_upd(int n);
        repeat (n) begin
            for (int i = 0; i <= 3000; i++) begin
                @(posedge pclk);
                if (value_update === 1'b1) break;
                if (i == 3000) hang();
            end
        end
    endtask
    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk("reg", rows[i].e, rd);
            chk("slverr", {31'h0, rows[i].er}, {31'h0, err});
        end
        // static level: ctrl, pin level, expected active flag
        foreach (st[i]) begin
            apb(1'b1, OFS_CTRL, {28'h0, st[i][7:4]});
            level <= st[i][1];
            repeat (4) @(posedge pclk);
            chk("active", {31'h0, st[i][0]}, {31'h0, input_active});
        end
        // over-range pulse rate clipped to the maximum, flagged in status
        level <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h03);
        period <= 8'h04;
        wait_upd(2);
        chk("freq", 32'h2710, proc_value);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("stat", 32'h2, rd);
        apb(1'b1, OFS_FMAX, 32'h186A0);
        apb(1'b1, OFS_LRV, 32'hFFFE7960);
        apb(1'b1, OFS_URV, 32'h7A120);
        apb(1'b1, OFS_DAMP, 32'h0);
        for (int v = 1; v <= 2; v++) begin
            apb(1'b1, OFS_CTRL, 32'h03 | (v << 4));
            period <= 8'h00;
            wait_upd(2);
            chk("lower", 32'hFFFE7960, proc_value);
            period <= 8'h08;
            wait_upd(2);
            chk("interp", 32'hFFFF9E58, proc_value, 600);
        end
        // two-sample average across a step from zero to saturation
        apb(1'b1, OFS_FMAX, 32'h2710);
        apb(1'b1, OFS_DAMP, 32'h2);
        period <= 8'h00;
        wait_upd(3);
        chk("damp_low", 32'hFFFE7960, proc_value);
        period <= 8'h04;
        wait_upd(1);
        chk("damp_mid", 32'h30D40, proc_value);
        wait_upd(1);
        chk("damp_top", 32'h7A120, proc_value);
        apb(1'b1, OFS_CTRL, 32'h05);
        repeat (3) @(posedge pclk);
        chk("cleared", 32'h0, proc_value);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl_rst", 32'h05, rd);
        results();
    end
endmodule // bipf_top_bench
